// *** csl_loader.sv ***
// shadow-RAM loader and write-back controller for a three-wire serial memory, plus its fifo
// assumes host requests and serial data input are synchronous to mclk_i

////////////////////////////////////////////////////////////////////////////////
module csl_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW:0] wp;
    logic [AW:0] rp;
  } csl_fifo_ptr_type;

  csl_fifo_ptr_type ptr_ff, nxt_ptr;
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic full;
  logic empty;

  assign full = (ptr_ff.wp[AW] != ptr_ff.rp[AW]) && (ptr_ff.wp[AW-1:0] == ptr_ff.rp[AW-1:0]);
  assign empty = (ptr_ff.wp == ptr_ff.rp);
  assign in_ready_o = !full;
  assign out_valid_o = !empty;
  assign out_data_o = mem_ff[ptr_ff.rp[AW-1:0]];

  always_comb begin
    nxt_ptr = ptr_ff;
    if (in_valid_i && !full) begin
      nxt_ptr.wp = ptr_ff.wp + 1'b1;
    end
    if (out_ready_i && !empty) begin
      nxt_ptr.rp = ptr_ff.rp + 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ptr_ff <= '0;
    end else begin
      ptr_ff <= nxt_ptr;
    end
  end

  always_ff @(posedge clk_i) begin
    if (in_valid_i && !full) begin
      mem_ff[ptr_ff.wp[AW-1:0]] <= in_data_i;
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////////
module csl_loader #(
  parameter int SHADOW_BYTES = 2048,
  parameter int FIFO_DEPTH = 4
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // host attribute-memory port
  input wire logic host_req_valid_i,
  input wire csl_pkg::csl_host_req_type host_req_i,
  output csl_pkg::csl_host_rsp_type host_rsp_o,
  output logic host_ireq_n_o,
  // card-side status
  input wire logic func_irq_i,
  input wire logic pwr_down_i,
  input wire logic rom_word_size_select_i,
  input wire logic rom_large_i,
  // serial memory pins
  input wire logic serial_rom_out_i,
  output logic serial_rom_select_o,
  output logic serial_rom_clock_o,
  output logic serial_rom_in_o
);
  localparam csl_pkg::csl_state_reg_type ST_RST = '{
    state: csl_pkg::S_LD_ISSUE,
    ret: csl_pkg::S_IDLE,
    page: csl_pkg::PAGE_RST,
    ctrl: csl_pkg::CTRL_RST,
    conf0: csl_pkg::CONF_RST,
    conf1: csl_pkg::CONF_RST,
    default: '0
  };

  csl_pkg::csl_state_reg_type st_ff, nxt_st;
  logic [7:0] shadow_ff [SHADOW_BYTES];
  logic mem_we;
  logic [10:0] mem_idx;
  logic [7:0] mem_wd;
  logic [5:0] aw;
  logic [5:0] dw;
  logic [10:0] word_last;
  logic [11:0] byte_end;
  logic [11:0] start_byte;
  logic configured;
  logic fifo_in_valid;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [7:0] fifo_out_data;
  logic sample;

  ////////////////////////////////////////////////////////////////////////////////
  // serial framing helpers
  function automatic logic [31:0] mk_tx(input logic [1:0] op, input logic [10:0] a,
                                        input logic [15:0] d, input logic [5:0] abits,
                                        input logic [5:0] dbits);
    logic [31:0] t;
    t = {29'h0, 1'b1, op};
    t = (t << abits) | {21'h0, a};
    t = (t << dbits) | {16'h0, d};
    mk_tx = t << (6'd32 - (csl_pkg::HDR_BITS + abits + dbits));
  endfunction

  function automatic csl_pkg::csl_state_reg_type launch(input csl_pkg::csl_state_reg_type s,
                                                        input logic [31:0] tx, input logic [5:0] ntx,
                                                        input logic [5:0] nb,
                                                        input csl_pkg::csl_state_type ret);
    csl_pkg::csl_state_reg_type r;
    r = s;
    r.state = csl_pkg::S_OP;
    r.ret = ret;
    r.tx = tx;
    r.di = tx[31];
    r.cs = 1'b1;
    r.sk = 1'b0;
    r.div = '0;
    r.bitcnt = '0;
    r.ntx = ntx;
    r.nbits = nb;
    r.rx = '0;
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // geometry from the straps
  assign aw = (rom_large_i ? csl_pkg::ABITS_LARGE : csl_pkg::ABITS_SMALL) - {5'h0, rom_word_size_select_i};
  assign dw = rom_word_size_select_i ? 6'h10 : 6'h08;
  assign word_last = 11'((12'h001 << aw) - 12'h001);
  assign byte_end = rom_large_i ? 12'h800 : 12'h200;
  assign start_byte = {7'h0, st_ff.page[csl_pkg::PAGE_W-1:0]} <<
                      (rom_large_i ? csl_pkg::PAGE_SHIFT_LARGE : csl_pkg::PAGE_SHIFT_SMALL);
  assign configured = st_ff.conf0[csl_pkg::CONF_BIT] || st_ff.conf1[csl_pkg::CONF_BIT];
  assign sample = (st_ff.state == csl_pkg::S_OP) && (st_ff.div == csl_pkg::DIV_RISE) &&
                  (st_ff.bitcnt >= st_ff.ntx);

  csl_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .in_valid_i(fifo_in_valid),
    .in_ready_o(fifo_in_ready),
    .in_data_i(shadow_ff[st_ff.fptr[10:0]]),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(fifo_out_ready),
    .out_data_o(fifo_out_data)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // next-state logic
  always_comb begin
    nxt_st = st_ff;
    nxt_st.rsp.ack = 1'b0;
    nxt_st.rsp.refused = 1'b0;
    mem_we = 1'b0;
    mem_idx = '0;
    mem_wd = '0;
    fifo_out_ready = 1'b0;
    // shadow bytes stream into the fifo ahead of the serial writes
    fifo_in_valid = st_ff.fill_on && (st_ff.fptr < byte_end);
    if (fifo_in_valid && fifo_in_ready) begin
      nxt_st.fptr = st_ff.fptr + 12'h001;
    end

    // host attribute access, only while idle
    if (host_req_valid_i) begin
      if (st_ff.state != csl_pkg::S_IDLE) begin
        nxt_st.rsp.refused = 1'b1;
        nxt_st.rsp.rdata = '0;
      end else begin
        nxt_st.rsp.ack = 1'b1;
        nxt_st.rsp.rdata = '0;
        if (host_req_i.addr < csl_pkg::ATTR_LIMIT && !host_req_i.addr[0]) begin
          nxt_st.rsp.rdata = shadow_ff[host_req_i.addr[11:1]];
          if (host_req_i.we) begin
            mem_we = 1'b1;
            mem_idx = host_req_i.addr[11:1];
            mem_wd = host_req_i.wdata;
          end
        end
        case (host_req_i.addr)
          csl_pkg::OFS_PAGE: begin
            nxt_st.rsp.rdata = st_ff.page;
            if (host_req_i.we) begin
              nxt_st.page = host_req_i.wdata;
            end
          end
          csl_pkg::OFS_CTRL: begin
            nxt_st.rsp.rdata = st_ff.ctrl;
            if (host_req_i.we) begin
              nxt_st.ctrl = host_req_i.wdata;
            end
          end
          csl_pkg::OFS_F0: begin
            nxt_st.rsp.rdata = st_ff.conf0;
            if (host_req_i.we) begin
              nxt_st.conf0 = host_req_i.wdata;
            end
          end
          csl_pkg::OFS_F1: begin
            nxt_st.rsp.rdata = st_ff.conf1;
            if (host_req_i.we) begin
              nxt_st.conf1 = host_req_i.wdata;
            end
          end
          default: begin
          end
        endcase
      end
    end

    case (st_ff.state)
      csl_pkg::S_LD_ISSUE: begin
        nxt_st = launch(nxt_st, mk_tx(csl_pkg::OP_READ, st_ff.waddr, 16'h0000, aw, 6'h00),
                        csl_pkg::HDR_BITS + aw, csl_pkg::HDR_BITS + aw + 6'h01 + dw,
                        csl_pkg::S_LD_STORE);
      end
      csl_pkg::S_LD_STORE: begin
        mem_we = 1'b1;
        mem_idx = rom_word_size_select_i ? {st_ff.waddr[9:0], st_ff.half} : st_ff.waddr;
        mem_wd = st_ff.half ? st_ff.rx[15:8] : st_ff.rx[7:0];
        if (mem_idx == csl_pkg::PAGE_SHADOW_IDX) begin
          nxt_st.page = mem_wd;
        end
        if (rom_word_size_select_i && !st_ff.half) begin
          nxt_st.half = 1'b1;
        end else begin
          nxt_st.half = 1'b0;
          nxt_st.waddr = st_ff.waddr + 11'h001;
          nxt_st.state = (st_ff.waddr == word_last) ? csl_pkg::S_IDLE : csl_pkg::S_LD_ISSUE;
        end
      end
      csl_pkg::S_IDLE: begin
        if (st_ff.ctrl[csl_pkg::CTRL_WR_BIT]) begin
          if (st_ff.ctrl[csl_pkg::CTRL_EN_BIT] && !configured && !pwr_down_i) begin
            nxt_st.waddr = 11'(start_byte >> rom_word_size_select_i);
            nxt_st.fptr = start_byte;
            nxt_st.fill_on = 1'b1;
            nxt_st.half = 1'b0;
            nxt_st = launch(nxt_st, mk_tx(csl_pkg::OP_CTL, 11'(csl_pkg::CTL_EWEN) << (aw - 6'h02),
                                          16'h0000, aw, 6'h00),
                            csl_pkg::HDR_BITS + aw, csl_pkg::HDR_BITS + aw,
                            csl_pkg::S_WB_FETCH);
          end else if (!(host_req_valid_i && host_req_i.we && host_req_i.addr == csl_pkg::OFS_CTRL)) begin
            // a request written in this same cycle wins over dropping the blocked one
            nxt_st.ctrl[csl_pkg::CTRL_WR_BIT] = 1'b0;
          end
        end
      end
      csl_pkg::S_OP: begin
        nxt_st.div = st_ff.div + 5'h01;
        nxt_st.sk = (nxt_st.div >= csl_pkg::DIV_RISE);
        if (sample) begin
          nxt_st.rx = {st_ff.rx[14:0], serial_rom_out_i};
        end
        if (st_ff.div == csl_pkg::DIV_LAST) begin
          if (st_ff.bitcnt == st_ff.nbits - 6'h01) begin
            nxt_st.cs = 1'b0;
            nxt_st.sk = 1'b0;
            nxt_st.di = 1'b0;
            nxt_st.state = csl_pkg::S_GAP;
          end else begin
            nxt_st.bitcnt = st_ff.bitcnt + 6'h01;
            nxt_st.tx = {st_ff.tx[30:0], 1'b0};
            nxt_st.di = st_ff.tx[30];
          end
        end
      end
      csl_pkg::S_GAP: begin
        nxt_st.div = st_ff.div + 5'h01;
        if (st_ff.div == csl_pkg::DIV_LAST) begin
          nxt_st.state = st_ff.ret;
        end
      end
      csl_pkg::S_WB_FETCH: begin
        if (!st_ff.ctrl[csl_pkg::CTRL_EN_BIT]) begin
          nxt_st.state = csl_pkg::S_WB_DIS;
        end else if (fifo_out_valid) begin
          fifo_out_ready = 1'b1;
          if (rom_word_size_select_i && !st_ff.half) begin
            nxt_st.wdata = {8'h00, fifo_out_data};
            nxt_st.half = 1'b1;
          end else begin
            nxt_st.half = 1'b0;
            nxt_st.wdata = rom_word_size_select_i ? {fifo_out_data, st_ff.wdata[7:0]} : {8'h00, fifo_out_data};
            nxt_st = launch(nxt_st, mk_tx(csl_pkg::OP_WRITE, st_ff.waddr, nxt_st.wdata, aw, dw),
                            csl_pkg::HDR_BITS + aw + dw, csl_pkg::HDR_BITS + aw + dw,
                            csl_pkg::S_WB_POLL);
          end
        end
      end
      csl_pkg::S_WB_POLL: begin
        if (!st_ff.cs) begin
          nxt_st.cs = 1'b1;
        end else if (serial_rom_out_i) begin
          nxt_st.cs = 1'b0;
          nxt_st.div = '0;
          nxt_st.state = csl_pkg::S_GAP;
          nxt_st.ret = (st_ff.waddr == word_last) ? csl_pkg::S_WB_DIS : csl_pkg::S_WB_FETCH;
          nxt_st.waddr = st_ff.waddr + 11'h001;
        end
      end
      csl_pkg::S_WB_DIS: begin
        nxt_st = launch(nxt_st, mk_tx(csl_pkg::OP_CTL, 11'(csl_pkg::CTL_EWDS) << (aw - 6'h02),
                                      16'h0000, aw, 6'h00),
                        csl_pkg::HDR_BITS + aw, csl_pkg::HDR_BITS + aw, csl_pkg::S_WB_END);
      end
      csl_pkg::S_WB_END: begin
        nxt_st.fill_on = 1'b0;
        fifo_out_ready = 1'b1;
        if (!fifo_out_valid) begin
          nxt_st.ctrl[csl_pkg::CTRL_WR_BIT] = 1'b0;
          nxt_st.state = csl_pkg::S_IDLE;
        end
      end
      default: begin
        nxt_st.state = csl_pkg::S_IDLE;
      end
    endcase

    // ready/busy until configured, function interrupt afterwards
    if (nxt_st.conf0[csl_pkg::CONF_BIT] || nxt_st.conf1[csl_pkg::CONF_BIT]) begin
      nxt_st.ireq_n = !func_irq_i;
    end else begin
      nxt_st.ireq_n = (nxt_st.state == csl_pkg::S_IDLE);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_ff <= ST_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (mem_we) begin
      shadow_ff[mem_idx] <= mem_wd;
    end
  end

  assign host_rsp_o = st_ff.rsp;
  assign host_ireq_n_o = st_ff.ireq_n;
  assign serial_rom_select_o = st_ff.cs;
  assign serial_rom_clock_o = st_ff.sk;
  assign serial_rom_in_o = st_ff.di;

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  // length of the current serial clock high phase
  logic [4:0] sk_hi_cnt_ff;
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sk_hi_cnt_ff <= 5'h00;
    end else if (st_ff.sk) begin
      sk_hi_cnt_ff <= sk_hi_cnt_ff + 5'h01;
    end else begin
      sk_hi_cnt_ff <= 5'h00;
    end
  end
  AST_SK_HALF: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    $fell(st_ff.sk) |-> sk_hi_cnt_ff == 5'h10)
    else $error("serial clock high phase is not 16 cycles");
  AST_SK_HIGH_MAX: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    st_ff.sk |-> sk_hi_cnt_ff < 5'h10)
    else $error("serial clock high phase longer than 16 cycles");
  AST_SK_IDLE: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    !st_ff.cs |-> !st_ff.sk)
    else $error("serial clock toggles without select");
  AST_DI_STABLE: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    $rose(st_ff.sk) |-> $stable(st_ff.di) && $past(st_ff.cs))
    else $error("data changed at serial clock rise");
  AST_START_BIT: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (st_ff.state == csl_pkg::S_OP && st_ff.bitcnt == 6'h00) |-> st_ff.di && st_ff.cs)
    else $error("operation does not begin with a start bit");
  AST_REFUSE_BUSY: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (host_req_valid_i && st_ff.state != csl_pkg::S_IDLE) |=> st_ff.rsp.refused && !st_ff.rsp.ack)
    else $error("host access taken while busy");
  AST_BUSY_LINE: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    !configured |-> (st_ff.ireq_n == (st_ff.state == csl_pkg::S_IDLE)))
    else $error("ready/busy does not follow the controller");
  AST_PWRDN: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (st_ff.state == csl_pkg::S_IDLE && pwr_down_i) |=> st_ff.state == csl_pkg::S_IDLE)
    else $error("write-back started in power-down");
  AST_CONF_BLOCK: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (st_ff.state == csl_pkg::S_IDLE && configured) |=> !st_ff.cs)
    else $error("write-back started while a function is configured");
  AST_EN_OFF: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (st_ff.state == csl_pkg::S_IDLE && !st_ff.ctrl[csl_pkg::CTRL_EN_BIT]) |=> !st_ff.cs)
    else $error("write-back started with enable clear");
  AST_READ_LEN: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (st_ff.state == csl_pkg::S_LD_ISSUE) |=> st_ff.nbits == $past(aw) + $past(dw) + 6'h04)
    else $error("read frame length wrong for word size");
endmodule

// *** csl_pkg.sv ***
// constants, types and state layout for the serial configuration-memory loader
// assumes a single 125 MHz clock and a synchronous host attribute-memory port
//
// Overview of operation
// - word-size input high: serial memory addressed as 16-bit words, low: 8-bit words
// - serial memory clock is the master clock divided by 32
// - both serial data lines sampled on rising serial clock; data stable before it
// - serial clock toggles only during an access, otherwise held low
// - after every reset the serial memory is read into the shadow RAM
// - during the boot load the busy line is asserted and host accesses refused
// - until a function is configured the interrupt line acts as ready/busy
// - write request plus enable, no function configured: shadow RAM copied to memory
// - all host attribute accesses are blocked for the whole write-back
// - write-back is write-enable command, data writes, then write-disable command
// - no write-back is started while power-down is signalled
// - each operation: start bit, opcode, address, data; select raised first
// - a reset pulse immediately disables serial memory writing
// - enable bit resets cleared; while cleared every write access is suppressed
// - five-bit start field at 0x3F0 gives upper address bits; lower locations untouched
// - 2 kB part: 11-bit address, field 0x07 starts writing at attribute 0x380
// - 512-byte part: 9-bit address, field 0x1F starts writing at attribute 0x3E0
// - no overwrite while configured bit D0 is set at 0x1020 or 0x1040
package csl_pkg;

  // attribute-space offsets
  localparam logic [12:0] OFS_PAGE = 13'h03f0;
  localparam logic [12:0] OFS_CTRL = 13'h1002;
  localparam logic [12:0] OFS_F0 = 13'h1020;
  localparam logic [12:0] OFS_F1 = 13'h1040;
  localparam logic [12:0] ATTR_LIMIT = 13'h1000;
  localparam logic [10:0] PAGE_SHADOW_IDX = OFS_PAGE[11:1];

  // field positions and reset values
  localparam int CTRL_WR_BIT = 0;
  localparam int CTRL_EN_BIT = 7;
  localparam int CONF_BIT = 0;
  localparam int PAGE_W = 5;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] CONF_RST = 8'h00;
  localparam logic [7:0] PAGE_RST = 8'h00;

  // serial clock timing in master clocks
  localparam int SK_DIV = 32;
  localparam logic [4:0] DIV_LAST = 5'(SK_DIV - 1);
  localparam logic [4:0] DIV_RISE = 5'(SK_DIV / 2);

  // serial memory geometry
  localparam logic [5:0] ABITS_LARGE = 6'h0b;
  localparam logic [5:0] ABITS_SMALL = 6'h09;
  localparam logic [5:0] PAGE_SHIFT_LARGE = 6'h06;
  localparam logic [5:0] PAGE_SHIFT_SMALL = 6'h04;
  localparam logic [5:0] HDR_BITS = 6'h03;

  // opcodes
  localparam logic [1:0] OP_READ = 2'b10;
  localparam logic [1:0] OP_WRITE = 2'b01;
  localparam logic [1:0] OP_CTL = 2'b00;
  localparam logic [1:0] CTL_EWEN = 2'b11;
  localparam logic [1:0] CTL_EWDS = 2'b00;

  typedef enum logic [3:0] {
    S_LD_ISSUE, S_LD_STORE, S_IDLE, S_OP, S_GAP,
    S_WB_FETCH, S_WB_POLL, S_WB_DIS, S_WB_END
  } csl_state_type;

  typedef struct packed {
    logic we;
    logic [12:0] addr;
    logic [7:0] wdata;
  } csl_host_req_type;

  typedef struct packed {
    logic ack;
    logic refused;
    logic [7:0] rdata;
  } csl_host_rsp_type;

  typedef struct packed {
    csl_state_type state;
    csl_state_type ret;
    logic [4:0] div;
    logic [5:0] bitcnt;
    logic [5:0] nbits;
    logic [5:0] ntx;
    logic [31:0] tx;
    logic [15:0] rx;
    logic [10:0] waddr;
    logic [11:0] fptr;
    logic fill_on;
    logic [15:0] wdata;
    logic half;
    logic cs;
    logic sk;
    logic di;
    logic ireq_n;
    csl_host_rsp_type rsp;
    logic [7:0] page;
    logic [7:0] ctrl;
    logic [7:0] conf0;
    logic [7:0] conf1;
  } csl_state_reg_type;

endpackage

// *** csl_rom_model.sv ***
// behavioural three-wire serial memory, 16-bit words, 256 words, fixed read pattern {~a, a}
// assumes the controller drives select, clock and data; each non-read frame is reported by a toggle
////////////////////////////////////////////////////////////////////////////////
module csl_rom_model #(
  parameter int AW = 8
) (
  // serial pins
  input wire logic serial_rom_select_i,
  input wire logic serial_rom_clock_i,
  input wire logic serial_rom_in_i,
  output logic serial_rom_out_o,
  // frame report
  output logic frame_stb_o,
  output logic [31:0] frame_o,
  output int frame_len_o,
  output int err_cnt_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] sh = '0;
  logic [AW-1:0] radr = '0;
  logic rdy = 1'b1;
  logic rd_phase = 1'b0;
  logic rd_bit = 1'b0;
  logic [15:0] rword = '0;
  logic idle_lvl = 1'b0;
  int n = 0;
  realtime last_rise = 0.0;
  initial begin
    frame_stb_o = 1'b0;
    frame_o = '0;
    frame_len_o = 0;
    err_cnt_o = 0;
  end
  // released line shows the inverse of its last value
  assign serial_rom_out_o = !serial_rom_select_i ? idle_lvl : (rd_phase ? rd_bit : rdy);
  always @(posedge serial_rom_select_i) begin
    n = 0;
    sh = '0;
    rd_phase = 1'b0;
  end
  always @(negedge serial_rom_select_i) begin
    idle_lvl = rd_phase ? ~rd_bit : ~rdy;
    if (n >= 3 && sh[n-2 -: 2] != 2'b10) begin
      frame_o = sh;
      frame_len_o = n;
      frame_stb_o = ~frame_stb_o;
      if (sh[n-2 -: 2] == 2'b01) begin
        rdy = 1'b0;
        rdy <= #1000 1'b1;
      end
    end
  end
  always @(posedge serial_rom_clock_i) begin
    if (!serial_rom_select_i) err_cnt_o++;
    if (n > 0 && $realtime - last_rise != 256.0) err_cnt_o++;
    if (n == 0 && serial_rom_in_i !== 1'b1) err_cnt_o++;
    last_rise = $realtime;
    sh = {sh[30:0], serial_rom_in_i};
    n++;
    if (n == 3 + AW) radr = sh[AW-1:0];
  end
  // read data changes after the falling clock, so it is stable at the next rise
  always @(negedge serial_rom_clock_i) begin
    if (n >= 3 + AW && sh[n-2 -: 2] == 2'b10) begin
      rd_phase = 1'b1;
      if (n == 3 + AW) begin
        rd_bit = 1'b0;
        rword = {~radr[7:0], radr[7:0]};
      end else if (n - 3 - AW <= 16) rd_bit = rword[19 + AW - n];
      else rd_bit = ~rd_bit;
    end
  end
endmodule

// *** csl_loader_tb.sv ***
// self-checking bench for the shadow loader: boot load, host port, blocked and real write-back
// assumes the small part in 16-bit organisation, so one boot load is 256 word reads
////////////////////////////////////////////////////////////////////////////////
module csl_loader_tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic refused; logic [7:0] rdata; bit chk;} csl_exp_type;
  logic mclk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic host_req_valid_i = 1'b0;
  logic func_irq_i = 1'b0;
  logic pwr_down_i = 1'b0;
  csl_pkg::csl_host_req_type host_req_i = '0;
  csl_pkg::csl_host_rsp_type host_rsp_o;
  logic host_ireq_n_o, serial_rom_out_i, serial_rom_select_o, serial_rom_clock_o, serial_rom_in_o;
  logic frame_stb;
  logic [31:0] frame, f;
  int frame_len, rom_err;
  int n_mismatch = 0;
  int check_count = 0;
  integer seed = 32'h27e9b73d;
  csl_exp_type hq[$];
  csl_exp_type e;
  logic [31:0] fq[$];
  logic [12:0] a;
  logic [12:0] cf[2] = '{csl_pkg::OFS_F0, csl_pkg::OFS_F1};
  always #4 mclk_i = ~mclk_i;
  csl_loader csl_loader_i (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .host_req_valid_i(host_req_valid_i),
    .host_req_i(host_req_i), .host_rsp_o(host_rsp_o), .host_ireq_n_o(host_ireq_n_o), .func_irq_i(func_irq_i),
    .pwr_down_i(pwr_down_i), .rom_word_size_select_i(1'b1), .rom_large_i(1'b0),
    .serial_rom_out_i(serial_rom_out_i), .serial_rom_select_o(serial_rom_select_o),
    .serial_rom_clock_o(serial_rom_clock_o), .serial_rom_in_o(serial_rom_in_o));
  csl_rom_model csl_rom_model_i (.serial_rom_select_i(serial_rom_select_o), .serial_rom_clock_i(serial_rom_clock_o),
    .serial_rom_in_i(serial_rom_in_o), .serial_rom_out_o(serial_rom_out_i), .frame_stb_o(frame_stb),
    .frame_o(frame), .frame_len_o(frame_len), .err_cnt_o(rom_err));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic end_sim();
    if (n_mismatch == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic req(input logic we, input logic [12:0] ad, input logic [7:0] d, input logic rf, input logic [7:0] ed,
                     input bit c);
    @(negedge mclk_i);
    host_req_valid_i <= 1'b1;
    host_req_i <= '{we, ad, d};
    hq.push_back('{rf, ed, c});
  endtask
  task automatic wr(input logic [12:0] ad, input logic [7:0] d);
    req(1'b1, ad, d, 1'b0, 8'h00, 1'b0);
  endtask
  task automatic rd(input logic [12:0] ad, input logic [7:0] ed);
    req(1'b0, ad, 8'h00, 1'b0, ed, 1'b1);
  endtask
  task automatic refuse(input logic [12:0] ad);
    req(1'b0, ad, 8'h00, 1'b1, 8'h00, 1'b1);
  endtask
  task automatic idle();
    @(negedge mclk_i);
    host_req_valid_i <= 1'b0;
  endtask
  task automatic wait_hi(input int lim);
    int k;
    k = 0;
    while (host_ireq_n_o !== 1'b1 && k < lim) begin
      @(negedge mclk_i);
      k++;
    end
    if (k >= lim) begin
      chk("ready timeout", 32'h1, 32'h0);
      end_sim();
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // response watcher: oldest note against each ack or refusal
  always @(negedge mclk_i) begin
    if (rst_n_i && (host_rsp_o.ack === 1'b1 || host_rsp_o.refused === 1'b1)) begin
      if (hq.size() == 0) chk("stray response", 32'h0, 32'h1);
      else begin
        e = hq.pop_front();
        chk("refused", {31'h0, e.refused}, {31'h0, host_rsp_o.refused});
        chk("ack", {31'h0, ~e.refused}, {31'h0, host_rsp_o.ack});
        if (e.chk) chk("rdata", {24'h0, e.rdata}, {24'h0, host_rsp_o.rdata});
      end
    end
  end
  // frame watcher: every write-side frame must have been expected
  always @(frame_stb) begin
    if ($time > 0) begin
      if (fq.size() == 0) chk("stray frame", 32'h0, 32'h1);
      else begin
        f = fq.pop_front();
        chk("frame length", {27'h0, f[31:27]}, 32'(frame_len));
        chk("frame bits", {5'h0, f[26:0]}, {5'h0, frame[26:0]});
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(negedge mclk_i);
    rst_n_i <= 1'b1;
    repeat (3) @(negedge mclk_i);
    chk("busy at boot", 32'h0, {31'h0, host_ireq_n_o});
    refuse(13'h0000);
    idle();
    wait_hi(400000);
    for (int i = 0; i < 12; i++) begin
      a = 13'($random(seed)) & 13'h03fe;
      rd(a, a[1] ? ~a[9:2] : a[9:2]);
    end
    rd(13'h0011, 8'h00);
    rd(13'h1010, 8'h00);
    rd(csl_pkg::OFS_CTRL, csl_pkg::CTRL_RST);
    rd(csl_pkg::OFS_F1, csl_pkg::CONF_RST);
    wr(csl_pkg::OFS_CTRL, 8'h01);
    idle();
    repeat (64) @(negedge mclk_i);
    rd(csl_pkg::OFS_CTRL, 8'h00);
    for (int j = 0; j < 3; j++) begin
      if (j < 2) wr(cf[j], 8'h01);
      pwr_down_i <= (j == 2);
      wr(csl_pkg::OFS_CTRL, 8'h81);
      idle();
      func_irq_i <= 1'b1;
      repeat (64) @(negedge mclk_i);
      chk("ready line", {31'h0, j == 2}, {31'h0, host_ireq_n_o});
      rd(csl_pkg::OFS_CTRL, 8'h80);
      idle();
      func_irq_i <= 1'b0;
      repeat (3) @(negedge mclk_i);
      chk("irq line", 32'h1, {31'h0, host_ireq_n_o});
      if (j < 2) wr(cf[j], 8'h00);
      idle();
    end
    pwr_down_i <= 1'b0;
    fq.push_back({5'd11, 16'h0, 11'h4c0});
    for (int w = 8'hf8; w <= 8'hff; w++) fq.push_back({5'd27, 3'b101, 8'(w), ~8'(w), w == 8'hfc ? 8'h1f : 8'(w)});
    fq.push_back({5'd11, 16'h0, 11'h400});
    wr(csl_pkg::OFS_PAGE, 8'h1f);
    wr(csl_pkg::OFS_CTRL, 8'h81);
    idle();
    repeat (8) @(negedge mclk_i);
    chk("busy in write-back", 32'h0, {31'h0, host_ireq_n_o});
    refuse(13'h0100);
    idle();
    wait_hi(30000);
    rd(csl_pkg::OFS_CTRL, 8'h80);
    idle();
    repeat (4) @(negedge mclk_i);
    chk("frames left", 32'h0, 32'(fq.size()));
    chk("responses left", 32'h0, 32'(hq.size()));
    chk("serial errors", 32'h0, 32'(rom_err));
    end_sim();
  end
endmodule
